// ===== src/fcsi_controller.sv
// Flash command, status and result interface with an APB register slave.
// Assumes an APB master on sys_clk; flash array timing is modelled by a fixed busy count.
//
// Operation
// - Command needs key 0x5A in top byte
// - Wrong key discards write, starts nothing
// - Program and lock take argument as page
// - Argument is bit number or ignored
// - Ready bit low while busy, high idle
// - Ready with enable raises interrupt request
// - Bad code or key sets command error
// - Locked region program or erase: lock error
// - Status read or command write clears errors
// - Result words read out in sequence
// - Reads past result return zero
// - Mode bit 0 enables ready interrupt
// - Out-of-range bit number changes nothing
`timescale 1ns/1ns
`default_nettype none

module fcsi_controller #(
    parameter int LOCK_BITS = 16,
    parameter int GENERAL_PURPOSE_NV_BIT_BITS = 3,
    parameter int REGION_SHIFT = 5,
    parameter int OP_CYCLES = 64,
    // Arbitrary version value.
    parameter logic [31:0] VERSION = 32'h00000100
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fcsi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    localparam int LOCK_IW = $clog2(LOCK_BITS);
    localparam int GP_IW = $clog2(GENERAL_PURPOSE_NV_BIT_BITS);
    localparam logic [7:0] LOCK_WORDS = 8'((LOCK_BITS + 31) / 32);
    localparam logic [7:0] GP_WORDS = 8'((GENERAL_PURPOSE_NV_BIT_BITS + 31) / 32);
    localparam logic [7:0] ONE_WORD = 8'h01;
    localparam int CNT_W = $clog2(OP_CYCLES + 1);

    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
    logic ready_q, ready_d, cmdErr_q, cmdErr_d, lockErr_q, lockErr_d, modeIrqEn_q, modeIrqEn_d;
    logic [fcsi_pkg::ST_W-1:0] evt_q, evt_d, mask_q, mask_d, statusBits;
    fcsi_pkg::fcsi_state_t state_q, state_d;
    fcsi_pkg::fcsi_cmd_t opCode_q, opCode_d;
    fcsi_pkg::fcsi_res_t resSrc_q, resSrc_d;
    logic [fcsi_pkg::ARG_W-1:0] opArg_q, opArg_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0] resIdx_q, resIdx_d, resWords_q, resWords_d;
    logic access, done, cmdWr, stRd, resRd, evtRd, keyOk, codeOk, start, cmdErrSet, lockErrSet;
    logic regionOk, gpOk, lockSet, lockClr, gpSet, gpClr, mapped;
    logic [LOCK_IW-1:0] regionIdx;
    logic [GP_IW-1:0] gpIdx;
    logic [LOCK_BITS-1:0] lockBits;
    logic [GENERAL_PURPOSE_NV_BIT_BITS-1:0] gpBits;
    logic [31:0] lockWord, gpWord, resWord, rdMux;

    function automatic logic validCode(input logic [fcsi_pkg::CODE_W-1:0] c);
        unique case (c)
            fcsi_pkg::CMD_WP, fcsi_pkg::CMD_WPL, fcsi_pkg::CMD_EWP, fcsi_pkg::CMD_EWPL, fcsi_pkg::CMD_EA,
            fcsi_pkg::CMD_SLB, fcsi_pkg::CMD_CLB, fcsi_pkg::CMD_GLB, fcsi_pkg::CMD_SGPB, fcsi_pkg::CMD_CGPB,
            fcsi_pkg::CMD_GGPB, fcsi_pkg::CMD_SSE, fcsi_pkg::CMD_GSE, fcsi_pkg::CMD_GVE: validCode = 1'b1;
            default: validCode = 1'b0;
        endcase
    endfunction : validCode

    // A transfer completes on the edge where the master sees pready high in its access phase.
    assign access = psel && penable;
    assign done = access && pready_q;
    assign cmdWr = done && pwrite && (paddr == fcsi_pkg::ADDR_CMD);
    assign stRd = done && !pwrite && (paddr == fcsi_pkg::ADDR_STATUS);
    assign resRd = done && !pwrite && (paddr == fcsi_pkg::ADDR_RESULT);
    assign evtRd = done && !pwrite && (paddr == fcsi_pkg::ADDR_EVT);
    assign keyOk = pwdata[fcsi_pkg::KEY_LSB +: fcsi_pkg::KEY_W] == fcsi_pkg::CMD_KEY;
    assign codeOk = validCode(pwdata[fcsi_pkg::CODE_W-1:0]);
    assign start = cmdWr && keyOk && codeOk && (state_q == fcsi_pkg::ST_IDLE);
    assign cmdErrSet = cmdWr && !(keyOk && codeOk);

    assign regionOk = (32'(opArg_q) >> REGION_SHIFT) < LOCK_BITS;
    assign regionIdx = LOCK_IW'(32'(opArg_q) >> REGION_SHIFT);
    assign gpOk = 32'(opArg_q) < GENERAL_PURPOSE_NV_BIT_BITS;
    // Security is general-purpose bit 0, whatever argument the command carried.
    assign gpIdx = (opCode_q == fcsi_pkg::CMD_SSE) ? '0 : GP_IW'(opArg_q);

    fcsi_bit_store #(.NBITS(LOCK_BITS), .IDX_W(LOCK_IW)) u_lockStore (
        .sys_clk(sys_clk),
        .rst(rst),
        .setEn(lockSet),
        .clrEn(lockClr),
        .bitIdx(regionIdx),
        .rdIdx(resIdx_q),
        .bits(lockBits),
        .rdWord(lockWord)
    );

    fcsi_bit_store #(.NBITS(GENERAL_PURPOSE_NV_BIT_BITS), .IDX_W(GP_IW)) u_gpStore (
        .sys_clk(sys_clk),
        .rst(rst),
        .setEn(gpSet),
        .clrEn(gpClr),
        .bitIdx(gpIdx),
        .rdIdx(resIdx_q),
        .bits(gpBits),
        .rdWord(gpWord)
    );

    // Operation sequencer and result pointer.
    always_comb begin
        state_d = state_q;
        opCode_d = opCode_q;
        opArg_d = opArg_q;
        cnt_d = cnt_q;
        ready_d = ready_q;
        resSrc_d = resSrc_q;
        resWords_d = resWords_q;
        resIdx_d = resIdx_q;
        lockErrSet = 1'b0;
        lockSet = 1'b0;
        lockClr = 1'b0;
        gpSet = 1'b0;
        gpClr = 1'b0;
        if (resRd && (resIdx_q < resWords_q)) begin
            resIdx_d = resIdx_q + ONE_WORD;
        end
        unique case (state_q)
            fcsi_pkg::ST_IDLE: begin
                if (start) begin
                    opCode_d = fcsi_pkg::fcsi_cmd_t'(pwdata[fcsi_pkg::CODE_W-1:0]);
                    opArg_d = pwdata[fcsi_pkg::ARG_LSB +: fcsi_pkg::ARG_W];
                    cnt_d = CNT_W'(OP_CYCLES - 1);
                    ready_d = 1'b0;
                    state_d = fcsi_pkg::ST_BUSY;
                end
            end
            fcsi_pkg::ST_BUSY: begin
                if (cnt_q == '0) begin
                    state_d = fcsi_pkg::ST_DONE;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            fcsi_pkg::ST_DONE: begin
                state_d = fcsi_pkg::ST_IDLE;
                ready_d = 1'b1;
                resIdx_d = '0;
                resWords_d = '0;
                unique case (opCode_q)
                    fcsi_pkg::CMD_WP, fcsi_pkg::CMD_EWP, fcsi_pkg::CMD_WPL, fcsi_pkg::CMD_EWPL: begin
                        lockErrSet = regionOk && lockBits[regionIdx];
                        lockSet = regionOk && (opCode_q == fcsi_pkg::CMD_WPL || opCode_q == fcsi_pkg::CMD_EWPL);
                    end
                    fcsi_pkg::CMD_EA: lockErrSet = |lockBits;
                    fcsi_pkg::CMD_SLB: lockSet = regionOk;
                    fcsi_pkg::CMD_CLB: lockClr = regionOk;
                    fcsi_pkg::CMD_SGPB: gpSet = gpOk;
                    fcsi_pkg::CMD_CGPB: gpClr = gpOk;
                    fcsi_pkg::CMD_SSE: gpSet = 1'b1;
                    fcsi_pkg::CMD_GLB: begin
                        resSrc_d = fcsi_pkg::RES_LOCK;
                        resWords_d = LOCK_WORDS;
                    end
                    fcsi_pkg::CMD_GGPB: begin
                        resSrc_d = fcsi_pkg::RES_GENERAL_PURPOSE_NV_BIT;
                        resWords_d = GP_WORDS;
                    end
                    fcsi_pkg::CMD_GSE: begin
                        resSrc_d = fcsi_pkg::RES_SEC;
                        resWords_d = ONE_WORD;
                    end
                    fcsi_pkg::CMD_GVE: begin
                        resSrc_d = fcsi_pkg::RES_VER;
                        resWords_d = ONE_WORD;
                    end
                    default: begin
                    end
                endcase
            end
            default: state_d = fcsi_pkg::ST_IDLE;
        endcase
    end

    // Status flags, sticky events, mode and mask. Clears only drop bits the read actually returned,
    // so an event landing during the read's wait cycle survives until the next read.
    always_comb begin
        cmdErr_d = cmdErr_q;
        lockErr_d = lockErr_q;
        evt_d = evt_q;
        modeIrqEn_d = modeIrqEn_q;
        mask_d = mask_q;
        if (cmdWr || (stRd && prdata_q[fcsi_pkg::ST_CMDERR])) begin
            cmdErr_d = 1'b0;
        end
        if (cmdWr || (stRd && prdata_q[fcsi_pkg::ST_LOCKERR])) begin
            lockErr_d = 1'b0;
        end
        if (evtRd) begin
            evt_d = evt_q & ~prdata_q[fcsi_pkg::ST_W-1:0];
        end
        if (cmdErrSet) begin
            cmdErr_d = 1'b1;
            evt_d[fcsi_pkg::ST_CMDERR] = 1'b1;
        end
        if (lockErrSet) begin
            lockErr_d = 1'b1;
            evt_d[fcsi_pkg::ST_LOCKERR] = 1'b1;
        end
        if (ready_d && !ready_q) begin
            evt_d[fcsi_pkg::ST_READY] = 1'b1;
        end
        if (done && pwrite && paddr == fcsi_pkg::ADDR_MODE) begin
            modeIrqEn_d = pwdata[fcsi_pkg::MODE_IRQEN];
        end
        if (done && pwrite && paddr == fcsi_pkg::ADDR_MASK) begin
            mask_d = pwdata[fcsi_pkg::ST_W-1:0];
        end
        irq_d = (ready_d && modeIrqEn_d) || |(evt_d & mask_d);
    end

    always_comb begin
        statusBits = '0;
        statusBits[fcsi_pkg::ST_READY] = ready_q;
        statusBits[fcsi_pkg::ST_CMDERR] = cmdErr_q;
        statusBits[fcsi_pkg::ST_LOCKERR] = lockErr_q;
        resWord = '0;
        if (resIdx_q < resWords_q) begin
            unique case (resSrc_q)
                fcsi_pkg::RES_LOCK: resWord = lockWord;
                fcsi_pkg::RES_GENERAL_PURPOSE_NV_BIT: resWord = gpWord;
                fcsi_pkg::RES_SEC: resWord = 32'(gpBits[0]);
                fcsi_pkg::RES_VER: resWord = VERSION;
            endcase
        end
        mapped = 1'b1;
        unique case (paddr)
            fcsi_pkg::ADDR_MODE: rdMux = 32'(modeIrqEn_q);
            fcsi_pkg::ADDR_STATUS: rdMux = 32'(statusBits);
            fcsi_pkg::ADDR_RESULT: rdMux = resWord;
            fcsi_pkg::ADDR_EVT: rdMux = 32'(evt_q);
            fcsi_pkg::ADDR_MASK: rdMux = 32'(mask_q);
            fcsi_pkg::ADDR_CMD: rdMux = '0;
            default: begin
                rdMux = '0;
                mapped = 1'b0;
            end
        endcase
    end

    // One wait cycle: read data is captured in the first access cycle and presented with pready.
    always_comb begin
        pready_d = access && !pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (access && !pready_q) begin
            pslverr_d = !mapped;
            prdata_d = pwrite ? '0 : rdMux;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            ready_q <= fcsi_pkg::READY_RESET;
            cmdErr_q <= 1'b0;
            lockErr_q <= 1'b0;
            evt_q <= fcsi_pkg::FLAGS_RESET;
            mask_q <= fcsi_pkg::FLAGS_RESET;
            modeIrqEn_q <= 1'b0;
            state_q <= fcsi_pkg::ST_IDLE;
            opCode_q <= fcsi_pkg::CMD_GVE;
            opArg_q <= '0;
            cnt_q <= '0;
            resSrc_q <= fcsi_pkg::RES_LOCK;
            resWords_q <= '0;
            resIdx_q <= '0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            ready_q <= ready_d;
            cmdErr_q <= cmdErr_d;
            lockErr_q <= lockErr_d;
            evt_q <= evt_d;
            mask_q <= mask_d;
            modeIrqEn_q <= modeIrqEn_d;
            state_q <= state_d;
            opCode_q <= opCode_d;
            opArg_q <= opArg_d;
            cnt_q <= cnt_d;
            resSrc_q <= resSrc_d;
            resWords_q <= resWords_d;
            resIdx_q <= resIdx_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_keyStarts;
        start |=> (state_q == fcsi_pkg::ST_BUSY) && !ready_q;
    endproperty
    a_keyStarts: assert property (p_keyStarts) else $error("good command did not start");

    property p_badKeyIdle;
        (cmdWr && !keyOk && state_q == fcsi_pkg::ST_IDLE) |=> (state_q == fcsi_pkg::ST_IDLE) && ready_q;
    endproperty
    a_badKeyIdle: assert property (p_badKeyIdle) else $error("bad key started an operation");

    property p_slbLocks;
        (state_q == fcsi_pkg::ST_DONE && opCode_q == fcsi_pkg::CMD_SLB && regionOk) |=> lockBits[$past(regionIdx)];
    endproperty
    a_slbLocks: assert property (p_slbLocks) else $error("lock command did not lock page region");

    property p_getResets;
        (state_q == fcsi_pkg::ST_DONE && opCode_q == fcsi_pkg::CMD_GLB) |=> resIdx_q == '0 && resWords_q == LOCK_WORDS;
    endproperty
    a_getResets: assert property (p_getResets) else $error("get command result not prepared");

    property p_readyRise;
        $rose(ready_q) |-> $past(state_q) == fcsi_pkg::ST_DONE;
    endproperty
    a_readyRise: assert property (p_readyRise) else $error("ready rose without completion");

    property p_readyIrq;
        (ready_q && modeIrqEn_q) |-> irq_q;
    endproperty
    a_readyIrq: assert property (p_readyIrq) else $error("ready interrupt missing");

    property p_cmdErr;
        cmdErrSet |=> cmdErr_q ##0 evt_q[fcsi_pkg::ST_CMDERR];
    endproperty
    a_cmdErr: assert property (p_cmdErr) else $error("command error not flagged");

    property p_lockErr;
        lockErrSet |=> lockErr_q;
    endproperty
    a_lockErr: assert property (p_lockErr) else $error("lock error not flagged");

    property p_errClear;
        (cmdWr && keyOk && codeOk && !lockErrSet) |=> !cmdErr_q && !lockErr_q;
    endproperty
    a_errClear: assert property (p_errClear) else $error("errors not cleared by command write");

    property p_resStep;
        (resRd && resIdx_q < resWords_q) |=> resIdx_q == $past(resIdx_q) + ONE_WORD;
    endproperty
    a_resStep: assert property (p_resStep) else $error("result pointer did not advance");

    property p_resZero;
        (resRd && resIdx_q >= resWords_q) |-> prdata_q == '0;
    endproperty
    a_resZero: assert property (p_resZero) else $error("extra result read not zero");

    property p_noIrq;
        (!modeIrqEn_q && (evt_q & mask_q) == '0) |-> !irq_q;
    endproperty
    a_noIrq: assert property (p_noIrq) else $error("interrupt with ready enable off");

    property p_rangeKeep;
        (state_q == fcsi_pkg::ST_DONE && opCode_q == fcsi_pkg::CMD_SLB && !regionOk) |=> $stable(lockBits);
    endproperty
    a_rangeKeep: assert property (p_rangeKeep) else $error("out-of-range lock changed state");

    property p_statusPad;
        stRd |-> prdata_q[31:fcsi_pkg::ST_W] == '0;
    endproperty
    a_statusPad: assert property (p_statusPad) else $error("unused status bits not zero");

endmodule : fcsi_controller
`default_nettype wire

// ===== src/fcsi_pkg.sv
// Package for the flash command and status interface.
// Holds register offsets, field layouts, reset values, command codes and state encodings.
package fcsi_pkg;

    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h60;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h64;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h6c;
    localparam logic [ADDR_W-1:0] ADDR_EVT = 8'h70;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h74;

    // Command word layout.
    localparam int KEY_LSB = 24;
    localparam int KEY_W = 8;
    localparam int ARG_LSB = 8;
    localparam int ARG_W = 16;
    localparam int CODE_W = 8;
    localparam logic [KEY_W-1:0] CMD_KEY = 8'h5a;

    // Status and event bit positions, shared by status, event and mask registers.
    localparam int ST_READY = 0;
    localparam int ST_CMDERR = 1;
    localparam int ST_LOCKERR = 2;
    localparam int ST_W = 3;
    localparam int MODE_IRQEN = 0;

    localparam logic READY_RESET = 1'b1;
    localparam logic [ST_W-1:0] FLAGS_RESET = 3'h0;

    typedef enum logic [CODE_W-1:0] {
        CMD_WP = 8'h12,
        CMD_WPL = 8'h22,
        CMD_EWP = 8'h32,
        CMD_EWPL = 8'h42,
        CMD_EA = 8'h13,
        CMD_SLB = 8'h14,
        CMD_CLB = 8'h24,
        CMD_GLB = 8'h15,
        CMD_SGPB = 8'h34,
        CMD_CGPB = 8'h44,
        CMD_GGPB = 8'h25,
        CMD_SSE = 8'h54,
        CMD_GSE = 8'h35,
        CMD_GVE = 8'h1e
    } fcsi_cmd_t;

    // Gray order along the path idle, busy, done.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BUSY = 2'h1,
        ST_DONE = 2'h3
    } fcsi_state_t;

    typedef enum logic [1:0] {
        RES_LOCK = 2'h0,
        RES_GENERAL_PURPOSE_NV_BIT = 2'h1,
        RES_SEC = 2'h2,
        RES_VER = 2'h3
    } fcsi_res_t;

endpackage : fcsi_pkg

// ===== src/fcsi_bit_store.sv
// Bit store for lock bits or general-purpose nonvolatile bits.
// Assumes single-bit set or clear requests; read word comes out of a register one cycle after its index.
`timescale 1ns/1ns
`default_nettype none

module fcsi_bit_store #(
    parameter int NBITS = 16,
    parameter int IDX_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic setEn,
    input wire logic clrEn,
    input wire logic [IDX_W-1:0] bitIdx,
    input wire logic [7:0] rdIdx,
    output logic [NBITS-1:0] bits,
    output logic [31:0] rdWord
);
    localparam int NWORDS = (NBITS + 31) / 32;

    logic [NBITS-1:0] bits_q, bits_d;
    logic [31:0] rdWord_q, rdWord_d;
    logic [NWORDS*32-1:0] padded;

    for (genvar i = 0; i < NBITS; i++) begin : g_bit
        always_comb begin
            bits_d[i] = bits_q[i];
            if (bitIdx == IDX_W'(i)) begin
                if (setEn) begin
                    bits_d[i] = 1'b1;
                end else if (clrEn) begin
                    bits_d[i] = 1'b0;
                end
            end
        end
    end

    always_comb begin
        padded = '0;
        padded[NBITS-1:0] = bits_q;
        rdWord_d = '0;
        if (32'(rdIdx) < NWORDS) begin
            rdWord_d = padded[32'(rdIdx) * 32 +: 32];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bits_q <= '0;
            rdWord_q <= '0;
        end else begin
            bits_q <= bits_d;
            rdWord_q <= rdWord_d;
        end
    end

    assign bits = bits_q;
    assign rdWord = rdWord_q;

endmodule : fcsi_bit_store
`default_nettype wire

// ===== testbench/test_flash_command_status_interface.sv
// Self-checking bench for the flash command and status interface.
// Assumes the controller's APB slave answers within a few cycles and a short busy count.
`timescale 1ns/1ns
`default_nettype none

module test_flash_command_status_interface;
    localparam int OpCycles = 8;
    localparam logic [31:0] Ver = 32'h00000100;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int mismatches = 0;
    int checks = 0;

    fcsi_controller #(.OP_CYCLES(OpCycles), .VERSION(Ver)) uut (
        .sys_clk(sys_clk),
        .rst(rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq)
    );

    always #2 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // The request is held until pready is sampled high, then released at that edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, data, d, e);
    endtask : wr

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h00000000, d, e);
        check(d, exp);
    endtask : rdchk

    task automatic cmd(input logic [7:0] code, input logic [15:0] arg);
        wr(fcsi_pkg::ADDR_CMD, {fcsi_pkg::CMD_KEY, arg, code});
    endtask : cmd

    // The busy span is fixed by the busy count, so a plain wait covers it with margin.
    task automatic settle;
        repeat (OpCycles + 4) @(posedge sys_clk);
    endtask : settle

    task automatic t_reset;
        logic [31:0] d;
        logic e;
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        rdchk(fcsi_pkg::ADDR_MODE, 32'h00000000);
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        check({31'h0, irq}, 32'h00000000);
        wr(fcsi_pkg::ADDR_STATUS, 32'hffffffff);
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        apb(1'b0, 8'h10, 32'h00000000, d, e);
        check({31'h0, e}, 32'h00000001);
    endtask : t_reset

    task automatic t_key;
        wr(fcsi_pkg::ADDR_CMD, {8'ha5, 16'h0000, 8'h14});
        repeat (3) @(posedge sys_clk);
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000003);
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        cmd(8'h99, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000003);
        cmd(8'h15, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
    endtask : t_key

    task automatic t_lock;
        cmd(8'h14, 16'h0040);
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000000);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        cmd(8'h15, 16'hffff);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000004);
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        cmd(8'h14, 16'h0200);
        settle();
        cmd(8'h15, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000004);
        cmd(8'h32, 16'h0045);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000005);
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        cmd(8'h12, 16'h0020);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        cmd(8'h13, 16'h1234);
        settle();
        cmd(8'h1e, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        rdchk(fcsi_pkg::ADDR_RESULT, Ver);
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        cmd(8'h24, 16'h0040);
        settle();
        cmd(8'h22, 16'h0020);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000001);
        cmd(8'h42, 16'h0020);
        settle();
        rdchk(fcsi_pkg::ADDR_STATUS, 32'h00000005);
        cmd(8'h15, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000002);
    endtask : t_lock

    task automatic t_gp;
        cmd(8'h34, 16'h0005);
        settle();
        cmd(8'h25, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        cmd(8'h34, 16'h0001);
        settle();
        cmd(8'h25, 16'hffff);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000002);
        cmd(8'h35, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        cmd(8'h44, 16'h0001);
        settle();
        cmd(8'h25, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000000);
        cmd(8'h54, 16'h0002);
        settle();
        cmd(8'h35, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000001);
        cmd(8'h25, 16'h0000);
        settle();
        rdchk(fcsi_pkg::ADDR_RESULT, 32'h00000001);
    endtask : t_gp

    task automatic t_irq;
        logic [31:0] d;
        logic e;
        wr(fcsi_pkg::ADDR_MODE, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h00000001);
        rdchk(fcsi_pkg::ADDR_MODE, 32'h00000001);
        cmd(8'h1e, 16'h0000);
        repeat (3) @(posedge sys_clk);
        check({31'h0, irq}, 32'h00000000);
        settle();
        check({31'h0, irq}, 32'h00000001);
        wr(fcsi_pkg::ADDR_MODE, 32'h00000000);
        apb(1'b0, fcsi_pkg::ADDR_EVT, 32'h00000000, d, e);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h00000000);
        wr(fcsi_pkg::ADDR_MASK, 32'h00000001);
        rdchk(fcsi_pkg::ADDR_MASK, 32'h00000001);
        cmd(8'h1e, 16'h0000);
        settle();
        check({31'h0, irq}, 32'h00000001);
        rdchk(fcsi_pkg::ADDR_EVT, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h00000000);
    endtask : t_irq

    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_key();
        t_lock();
        t_gp();
        t_irq();
        repeat (4) @(posedge sys_clk);
        give_verdict();
    end
endmodule : test_flash_command_status_interface

`default_nettype wire
